// [core/smlc_muting.sv]
// Purpose: muting sequencer with APB registers
// Assumes: sensor and curtain pins are asynchronous levels
// Notes: one tick per time step drives all timers
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
module smlc_muting
  import smlc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SMLC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field pins
  input wire logic lightCurtainInput,
  input wire logic discrepancyError,
  input wire logic entrySensorFirst,
  input wire logic entrySensorSecond,
  input wire logic exitSensorFirst,
  input wire logic exitSensorSecond,
  // Machine side
  output logic outputPermit,
  output logic mutingStatus,
  output logic sequenceError,
  output logic syncError,
  output logic faultPresent
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    smlc_state_t state;
    logic permit;
    logic muteStatus;
    logic seqErr;
    logic syncErr;
    logic fault;
    logic revDir;
    logic runPrev;
    logic ctlRun;
    logic [1:0] mode;
    logic [8:0] syncSet;
    logic [7:0] maxSet;
    logic [3:0] sensPrev;
    logic [TICK_W-1:0] tickCnt;
    logic tick;
    logic [8:0] syncCnt;
    logic [13:0] muteCnt;
    logic [31:0] prdata;
  } smlc_regs_t;

  smlc_regs_t st;
  smlc_regs_t next_st;
  logic [5:0] pinSync;
  logic light;
  logic disc;
  logic [3:0] sens;
  logic [3:0] rise;
  logic [3:0] fall;
  logic runRise;
  logic bidir;
  logic syncExp;
  logic maxExp;
  logic goMute;
  logic endMute;
  logic [13:0] muteLimit;
  logic [3:0] firstBit;
  logic [3:0] secondBit;

  // Sensors on the number of interrupted beams
  function automatic logic [2:0] onCount(input logic [3:0] s);
    onCount = 3'(s[0]) + 3'(s[1]) + 3'(s[2]) + 3'(s[3]);
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == SMLC_OFS_CTRL) || (a == SMLC_OFS_SYNC) ||
      (a == SMLC_OFS_MAXMUTE) || (a == SMLC_OFS_STATUS);
  endfunction

  // Sensor whose release ends muting, by mode and direction
  function automatic int clearIdx(input logic [1:0] m, input logic rev);
    if (m == SMLC_PARALLEL) clearIdx = SMLC_ENTRY1;
    else if (m == SMLC_BOTH && rev) clearIdx = SMLC_ENTRY2;
    else clearIdx = SMLC_EXIT1;
  endfunction

  // Out-of-range sync settings are clamped rather than refused
  function automatic logic [8:0] clampSync(input logic [31:0] v);
    if (v < 32'(SMLC_SYNC_MIN)) clampSync = SMLC_SYNC_MIN;
    else if (v > 32'(SMLC_SYNC_MAX)) clampSync = SMLC_SYNC_MAX;
    else clampSync = v[8:0];
  endfunction

  // Pins cross into the clock domain
  smlc_sync #(
    .WIDTH(6)
  ) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .asyncIn({exitSensorSecond, exitSensorFirst, entrySensorSecond,
              entrySensorFirst, discrepancyError, lightCurtainInput}),
    .syncOut(pinSync)
  );

  assign light = pinSync[0];
  assign disc = pinSync[1];
  assign sens = pinSync[5:2];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~isMapped(paddr);
  assign prdata = st.prdata;
  assign outputPermit = st.permit;
  assign mutingStatus = st.muteStatus;
  assign sequenceError = st.seqErr;
  assign syncError = st.syncErr;
  assign faultPresent = st.fault;

  // Edge terms and timer limits
  assign rise = sens & ~st.sensPrev;
  assign fall = ~sens & st.sensPrev;
  assign runRise = st.ctlRun & ~st.runPrev;
  assign bidir = (st.mode == SMLC_BOTH);
  assign syncExp = (st.syncCnt >= st.syncSet);
  assign muteLimit = {6'h00, st.maxSet} * SMLC_MUTE_STEP_TICKS;
  assign maxExp = (st.maxSet != 8'h00) && (st.muteCnt >= muteLimit);
  assign firstBit = st.revDir ? 4'h8 : 4'h1;
  assign secondBit = st.revDir ? 4'h4 : 4'h2;

  // Next state: sequencer, flags, timers and register writes
  always_comb begin
    next_st = st;
    goMute = 1'b0;
    endMute = 1'b0;
    next_st.runPrev = st.ctlRun;
    next_st.sensPrev = sens;
    next_st.tick = 1'b0;
    // Time-step tick for all timers
    if (st.tickCnt == TICK_W'(TICK_CYCLES - 1)) begin
      next_st.tickCnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tickCnt = st.tickCnt + 1'b1;
    end
    case (st.state)
      S_IDLE: begin
        if (st.ctlRun) next_st.state = S_ARM;
      end
      S_ARM: begin
        if (sens == 4'h0) next_st.state = S_READY;
      end
      S_READY: begin
        if (st.mode == SMLC_POSITION) begin
          if (sens[SMLC_ENTRY1] && st.permit) goMute = 1'b1;
        end else if (rise != 4'h0) begin
          if (!st.permit) begin
            next_st.state = S_ARM;
          end else if (rise == 4'h1) begin
            next_st.state = S_FIRST;
            next_st.revDir = 1'b0;
            next_st.syncCnt = 9'h000;
          end else if (bidir && rise == 4'h8) begin
            next_st.state = S_FIRST;
            next_st.revDir = 1'b1;
            next_st.syncCnt = 9'h000;
          end else begin
            next_st.seqErr = 1'b1;
            next_st.state = S_ARM;
          end
        end
      end
      S_FIRST: begin
        if (st.tick && !syncExp) next_st.syncCnt = st.syncCnt + 9'h001;
        if (!st.permit) begin
          next_st.state = S_ARM;
        end else if (rise == secondBit && sens == (firstBit | secondBit))
        begin
          goMute = 1'b1;
        end else if (rise != 4'h0 || (sens & firstBit) == 4'h0) begin
          next_st.seqErr = 1'b1;
          next_st.state = S_ARM;
        end else if (bidir && syncExp) begin
          next_st.syncErr = 1'b1;
          next_st.state = S_ARM;
        end
      end
      S_MUTE: begin
        if (st.tick && !maxExp) next_st.muteCnt = st.muteCnt + 14'h0001;
        if (st.mode == SMLC_POSITION) begin
          endMute = disc || maxExp || !sens[SMLC_ENTRY1];
        end else begin
          endMute = disc || maxExp || (onCount(sens) < 3'h2) ||
            fall[clearIdx(st.mode, st.revDir)];
        end
        if (endMute) next_st.state = S_ARM;
      end
      default: begin
        next_st.state = S_IDLE;
      end
    endcase
    // Entering muting clears the sequence and sync flags
    if (goMute) begin
      next_st.state = S_MUTE;
      next_st.seqErr = 1'b0;
      next_st.syncErr = 1'b0;
      next_st.muteCnt = 14'h0000;
    end
    // Fault follows discrepancy and clears with light
    if (disc) next_st.fault = 1'b1;
    else if (light) next_st.fault = 1'b0;
    // Run entry restarts the sequencer from all-off
    if (!st.ctlRun) begin
      next_st.state = S_IDLE;
    end else if (runRise) begin
      next_st.state = S_ARM;
      next_st.syncErr = 1'b0;
      next_st.seqErr = ~light;
      next_st.fault = ~light | disc;
    end
    next_st.muteStatus = (next_st.state == S_MUTE);
    // Muting holds the permit; otherwise it needs light
    next_st.permit = st.ctlRun &&
      ((light && !disc) || next_st.muteStatus);
    // Register writes take effect in the access phase
    if (psel && penable && pwrite) begin
      case (paddr)
        SMLC_OFS_CTRL: begin
          next_st.ctlRun = pwdata[SMLC_CTRL_RUN];
          next_st.mode = pwdata[SMLC_CTRL_MODE +: 2];
        end
        SMLC_OFS_SYNC: next_st.syncSet = clampSync(pwdata);
        SMLC_OFS_MAXMUTE: next_st.maxSet = pwdata[7:0];
        default: next_st.ctlRun = st.ctlRun;
      endcase
    end
    // Read data is captured in setup so access needs no wait
    if (psel && !penable) begin
      next_st.prdata = 32'h0000_0000;
      case (paddr)
        SMLC_OFS_CTRL: begin
          next_st.prdata[SMLC_CTRL_RUN] = st.ctlRun;
          next_st.prdata[SMLC_CTRL_MODE +: 2] = st.mode;
        end
        SMLC_OFS_SYNC: next_st.prdata[8:0] = st.syncSet;
        SMLC_OFS_MAXMUTE: next_st.prdata[7:0] = st.maxSet;
        SMLC_OFS_STATUS: begin
          next_st.prdata[SMLC_ST_PERMIT] = st.permit;
          next_st.prdata[SMLC_ST_MUTE] = st.muteStatus;
          next_st.prdata[SMLC_ST_SEQERR] = st.seqErr;
          next_st.prdata[SMLC_ST_SYNCERR] = st.syncErr;
          next_st.prdata[SMLC_ST_FAULT] = st.fault;
          next_st.prdata[SMLC_ST_LIGHT] = light;
          next_st.prdata[SMLC_ST_DISC] = disc;
          next_st.prdata[SMLC_ST_REV] = st.revDir;
          next_st.prdata[SMLC_ST_SENS +: 4] = sens;
        end
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end
  end

  // State register with safe reset values
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.state <= S_IDLE;
      st.mode <= SMLC_MODE_RESET;
      st.syncSet <= SMLC_SYNC_RESET;
      st.maxSet <= SMLC_MAXMUTE_RESET;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_runEntry;
    st.ctlRun && !st.runPrev && !light;
  endsequence

  sequence s_muteStart;
    !st.muteStatus ##1 st.muteStatus;
  endsequence

  permit_light_a: assert property (
    st.permit |-> ($past(light) && !$past(disc)) || st.muteStatus)
    else $error("permit without light or muting");
  mute_hold_a: assert property (
    st.muteStatus |-> st.permit)
    else $error("muting without permit");
  start_permit_a: assert property (
    s_muteStart |-> $past(st.permit))
    else $error("muting started without permit");
  seq_order_a: assert property (
    st.state == S_READY && st.permit && st.ctlRun && st.runPrev &&
    st.mode != SMLC_POSITION && rise != 4'h0 && rise != 4'h1 &&
    !(bidir && rise == 4'h8) |=> st.seqErr && st.state == S_ARM)
    else $error("bad order not flagged");
  sync_late_a: assert property (
    st.state == S_FIRST && bidir && syncExp && st.permit &&
    rise == 4'h0 && (sens & firstBit) != 4'h0 && st.ctlRun &&
    st.runPrev |=> st.syncErr)
    else $error("late second sensor not flagged");
  dark_drop_a: assert property (
    !light && !next_st.muteStatus |=> !st.permit)
    else $error("permit held while dark");
  mute_end_a: assert property (
    st.muteStatus && st.mode != SMLC_POSITION &&
    onCount(sens) < 3'h2 |=> !st.muteStatus)
    else $error("muting kept with under two sensors");
  end_dark_a: assert property (
    st.muteStatus ##1 !st.muteStatus && !$past(light) |-> !st.permit)
    else $error("permit kept after muting ended dark");
  run_entry_a: assert property (
    s_runEntry |=> st.fault && st.seqErr && st.state == S_ARM)
    else $error("run entry flags missing");
  err_clear_a: assert property (
    s_muteStart |-> !st.seqErr && !st.syncErr)
    else $error("errors kept at muting start");
endmodule // smlc_muting

// [core/smlc_pkg.sv]
// Purpose: constants and types for the safety muting logic
// Assumes: 125 MHz clock, APB register access
// Notes: all timing figures derive from the 10 ms time step
//
// What this block does
// - Permit needs light incident and no discrepancy
// - Muting starts after all-off, ordered pair
// - Wrong sensor order raises sequence error
// - Late second sensor raises sync error
// - Sync time defaults to three seconds
// - Dark curtain before muting drops permit
// - Muting ends: under two, timeout, discrepancy
// - Muting end with dark curtain drops permit
// - Run entry with inputs off flags fault
// - Run-entry sequence error clears on muting start
// - Parallel mode: first pair sensor gates muting
// - Muting keeps permit despite obstructed curtain
// - Forward mode: entry pair starts, exit ends
// - Both-direction mode also starts on reverse pair
// - Both-direction mode ends per travel direction
// - Position mode: one sensor, no checks
// - Sync time 30 ms to 3 s, 10 ms
// - Max muting time 500 ms steps, zero unlimited
// - Sync errors only in both-direction mode
// - Errors clear on muting; run re-entry clears sync error, sets sequence error if dark
package smlc_pkg;
  // Timing base
  localparam int unsigned SMLC_CLOCK_HZ = 125_000_000;
  localparam int unsigned SMLC_TICK_MS = 10;
  localparam int unsigned SMLC_TICK_CYCLES =
    SMLC_CLOCK_HZ / 1000 * SMLC_TICK_MS;
  localparam int unsigned SMLC_MUTE_STEP_MS = 500;
  localparam logic [13:0] SMLC_MUTE_STEP_TICKS =
    14'(SMLC_MUTE_STEP_MS / SMLC_TICK_MS);
  localparam int unsigned SMLC_SYNC_MIN_MS = 30;
  localparam int unsigned SMLC_SYNC_MAX_MS = 3000;
  localparam int unsigned SMLC_SYNC_DEF_MS = 3000;
  localparam logic [8:0] SMLC_SYNC_MIN = 9'(SMLC_SYNC_MIN_MS / SMLC_TICK_MS);
  localparam logic [8:0] SMLC_SYNC_MAX = 9'(SMLC_SYNC_MAX_MS / SMLC_TICK_MS);
  localparam logic [8:0] SMLC_SYNC_RESET =
    9'(SMLC_SYNC_DEF_MS / SMLC_TICK_MS);
  localparam logic [7:0] SMLC_MAXMUTE_RESET = 8'h78; // 60 s
  // Register offsets
  localparam logic [7:0] SMLC_OFS_CTRL = 8'h00;
  localparam logic [7:0] SMLC_OFS_SYNC = 8'h04;
  localparam logic [7:0] SMLC_OFS_MAXMUTE = 8'h08;
  localparam logic [7:0] SMLC_OFS_STATUS = 8'h0C;
  // Control fields
  localparam int SMLC_CTRL_RUN = 0;
  localparam int SMLC_CTRL_MODE = 1;
  // Status fields
  localparam int SMLC_ST_PERMIT = 0;
  localparam int SMLC_ST_MUTE = 1;
  localparam int SMLC_ST_SEQERR = 2;
  localparam int SMLC_ST_SYNCERR = 3;
  localparam int SMLC_ST_FAULT = 4;
  localparam int SMLC_ST_LIGHT = 5;
  localparam int SMLC_ST_DISC = 6;
  localparam int SMLC_ST_REV = 7;
  localparam int SMLC_ST_SENS = 8;
  // Sensor bit positions
  localparam int SMLC_ENTRY1 = 0;
  localparam int SMLC_ENTRY2 = 1;
  localparam int SMLC_EXIT1 = 2;
  localparam int SMLC_EXIT2 = 3;
  localparam logic [1:0] SMLC_MODE_RESET = 2'h0;
  typedef enum logic [1:0] {
    SMLC_PARALLEL = 2'h0,
    SMLC_FORWARD = 2'h1,
    SMLC_BOTH = 2'h2,
    SMLC_POSITION = 2'h3
  } smlc_mode_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_ARM = 5'h02,
    S_READY = 5'h04,
    S_FIRST = 5'h08,
    S_MUTE = 5'h10
  } smlc_state_t;
endpackage

// [core/smlc_sync.sv]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are slow levels relative to the clock
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module smlc_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // Metastability filter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // smlc_sync

// [testbench/smlc_field_model.sv]
// Purpose: field model of light curtain, discrepancy and muting sensors
// Assumes: bench sets the wanted pin levels and a switching lag
// Notes: lag imitates slow sensors; levels never float, no release case
`timescale 1ns/1ps
module smlc_field_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Command from bench: {disc, light, exit2, exit1, entry2, entry1}
  input wire logic [5:0] target,
  input wire logic [1:0] lag,
  // Field pins
  output logic [5:0] pins
);
  logic [1:0] holdCnt;

  // Slow switching: new levels appear lag cycles late
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pins <= 6'h00;
      holdCnt <= 2'h0;
    end else if (pins != target && holdCnt < lag) begin
      holdCnt <= holdCnt + 2'h1;
    end else begin
      pins <= target;
      holdCnt <= 2'h0;
    end
  end
endmodule // smlc_field_model

// [testbench/smlc_muting_tb_top.sv]
// Purpose: self-checking bench for the muting sequencer
// Assumes: tick shortened to 10 cycles, all times scale with it
// Notes: output checks wait out synchroniser and model lag
`timescale 1ns/1ps
module smlc_muting_tb_top
  import smlc_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, rv;
  logic pready, pslverr, er;
  logic [5:0] tgt = 6'h00;
  logic [1:0] lag = 2'h0;
  logic [5:0] pins;
  logic outputPermit, mutingStatus, sequenceError, syncError, faultPresent;
  int bad_count = 0;
  int cmp_count = 0;

  // 125 MHz clock
  always #4 clock = ~clock;

  smlc_field_model field (.clock(clock), .rst_b(rst_b), .target(tgt),
    .lag(lag), .pins(pins));

  smlc_muting #(.TICK_CYCLES(10)) uut (.clock(clock), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lightCurtainInput(pins[4]), .discrepancyError(pins[5]),
    .entrySensorFirst(pins[0]), .entrySensorSecond(pins[1]),
    .exitSensorFirst(pins[2]), .exitSensorSecond(pins[3]),
    .outputPermit(outputPermit), .mutingStatus(mutingStatus),
    .sequenceError(sequenceError), .syncError(syncError),
    .faultPresent(faultPresent));

  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  // APB transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never completes
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic ee);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd);
    chk("pslverr", 32'(ee), 32'(er));
  endtask

  // Expected sync setting; out-of-range writes clamp to the limits
  function automatic logic [31:0] syncClampExp(input logic [31:0] v);
    if (v < 32'(SMLC_SYNC_MIN)) return 32'(SMLC_SYNC_MIN);
    if (v > 32'(SMLC_SYNC_MAX)) return 32'(SMLC_SYNC_MAX);
    return v;
  endfunction

  // Expected outputs; permit derived from curtain, discrepancy, muting
  function automatic logic [4:0] ev(input logic m, s, y, f);
    return {f, y, s, m, m | (tgt[4] & ~tgt[5])};
  endfunction

  task automatic co(input logic m, s, y, f);
    chk("outputs", 32'(ev(m, s, y, f)), 32'({faultPresent, syncError,
      sequenceError, mutingStatus, outputPermit}));
  endtask

  // New field levels, random lag, then let them settle
  task automatic st(input logic [5:0] p);
    tgt <= p;
    lag <= 2'($urandom_range(0, 3));
    repeat (9 + $urandom_range(0, 2)) @(posedge clock);
  endtask

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h87dc));
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    co(0, 0, 0, 0);
    rdc(SMLC_OFS_CTRL, 32'h0, 1'b0);
    rdc(SMLC_OFS_SYNC, 32'(SMLC_SYNC_RESET), 1'b0);
    rdc(SMLC_OFS_MAXMUTE, 32'(SMLC_MAXMUTE_RESET), 1'b0);
    rdc(8'h10, 32'h0, 1'b1);
    // Sync setting: both limits first, then random values
    for (int i = 0; i < 6; i++) begin
      rv = (i == 0) ? 32'h2 : (i == 1) ? 32'h12D :
        32'($urandom_range(0, 511));
      apb(1'b1, SMLC_OFS_SYNC, rv);
      rdc(SMLC_OFS_SYNC, syncClampExp(rv), 1'b0);
    end
    // Run entry with curtain input still off
    apb(1'b1, SMLC_OFS_CTRL, 32'h1);
    st(6'h00);
    co(0, 1, 0, 1);
    st(6'h10);
    co(0, 1, 0, 0);
    // Parallel pair; curtain then blocked and released
    st(6'h11);
    st(6'h13);
    co(1, 0, 0, 0);
    rdc(SMLC_OFS_STATUS, 32'h323, 1'b0);
    st(6'h03);
    co(1, 0, 0, 0);
    st(6'h02);
    co(0, 0, 0, 0);
    st(6'h00);
    st(6'h10);
    st(6'h01);
    co(0, 0, 0, 0);
    st(6'h10);
    st(6'h12);
    co(0, 1, 0, 0);
    st(6'h10);
    // Discrepancy during muting
    st(6'h11);
    st(6'h13);
    st(6'h33);
    co(0, 0, 0, 1);
    st(6'h10);
    co(0, 0, 0, 0);
    // Max muting time one step, then unlimited
    apb(1'b1, SMLC_OFS_MAXMUTE, 32'h1);
    st(6'h11);
    st(6'h13);
    repeat (400) @(posedge clock);
    co(1, 0, 0, 0);
    repeat (150) @(posedge clock);
    co(0, 0, 0, 0);
    st(6'h10);
    apb(1'b1, SMLC_OFS_MAXMUTE, 32'h0);
    st(6'h11);
    st(6'h13);
    repeat (700) @(posedge clock);
    co(1, 0, 0, 0);
    st(6'h10);
    // Forward: exit pair takes over, exit1 falling ends
    apb(1'b1, SMLC_OFS_CTRL, 32'h3);
    st(6'h11);
    st(6'h13);
    st(6'h17);
    st(6'h1F);
    st(6'h1C);
    co(1, 0, 0, 0);
    st(6'h18);
    co(0, 0, 0, 0);
    st(6'h10);
    // Both directions, short sync time, reverse travel
    apb(1'b1, SMLC_OFS_SYNC, 32'h3);
    apb(1'b1, SMLC_OFS_CTRL, 32'h5);
    st(6'h18);
    st(6'h1C);
    co(1, 0, 0, 0);
    st(6'h1F);
    st(6'h1D);
    co(0, 0, 0, 0);
    st(6'h10);
    st(6'h11);
    repeat (50) @(posedge clock);
    co(0, 0, 1, 0);
    st(6'h10);
    st(6'h11);
    st(6'h13);
    co(1, 0, 0, 0);
    // Forward travel in both-direction mode ends on exit1
    st(6'h1F);
    st(6'h1C);
    co(1, 0, 0, 0);
    st(6'h18);
    co(0, 0, 0, 0);
    st(6'h10);
    // Forward waits with no sync timeout
    apb(1'b1, SMLC_OFS_CTRL, 32'h3);
    st(6'h11);
    repeat (50) @(posedge clock);
    co(0, 0, 0, 0);
    st(6'h13);
    co(1, 0, 0, 0);
    st(6'h10);
    // Position: one sensor alone
    apb(1'b1, SMLC_OFS_CTRL, 32'h7);
    st(6'h11);
    co(1, 0, 0, 0);
    st(6'h10);
    co(0, 0, 0, 0);
    // Run re-entry clears a sequence error
    apb(1'b1, SMLC_OFS_CTRL, 32'h1);
    st(6'h12);
    st(6'h10);
    co(0, 1, 0, 0);
    apb(1'b1, SMLC_OFS_CTRL, 32'h0);
    apb(1'b1, SMLC_OFS_CTRL, 32'h1);
    st(6'h10);
    co(0, 0, 0, 0);
    end_sim();
  end
endmodule // smlc_muting_tb_top
